// File: hdl/rtcaic_pkg.sv
package rtcaic_pkg;
	// register map
	localparam logic [7:0] ADDR_CAL_LAST = 8'h06;
	localparam logic [7:0] ADDR_ALM1_SEC = 8'h07;
	localparam logic [7:0] ADDR_ALM2_DAY = 8'h0D;
	localparam logic [7:0] ADDR_CONTROL = 8'h0E;
	localparam logic [7:0] ADDR_STATUS = 8'h0F;
	localparam int ALM_REGS = 7;
	// calendar register indices
	localparam logic [2:0] CAL_SEC = 3'h0;
	localparam logic [2:0] CAL_MIN = 3'h1;
	localparam logic [2:0] CAL_HOUR = 3'h2;
	localparam logic [2:0] CAL_WDAY = 3'h3;
	localparam logic [2:0] CAL_DATE = 3'h4;
	localparam logic [2:0] CAL_MONTH = 3'h5;
	// alarm field layout
	localparam int ALM_MASK_BIT = 7;
	localparam int ALM_DAYSEL_BIT = 6;
	// control bits
	localparam int CTL_FREE = 7;
	localparam int CTL_WAIT = 5;
	localparam int CTL_RS_HI = 4;
	localparam int CTL_RS_LO = 3;
	localparam int CTL_ROUTE = 2;
	localparam int CTL_ALARM_TWO_IRQ_ENABLE = 1;
	localparam int CTL_ALARM_ONE_IRQ_ENABLE = 0;
	// status bits
	localparam int STS_OSF = 7;
	localparam int STS_TSA = 2;
	localparam int STS_A2F = 1;
	localparam int STS_A1F = 0;
	// power-on values
	localparam logic CTL_WAIT_RST = 1'h1;
	localparam logic [1:0] CTL_RS_RST = 2'h3;
	localparam logic STS_OSF_RST = 1'h1;
	// rate select codes
	localparam logic [1:0] RS_1HZ = 2'h0;
	localparam logic [1:0] RS_4096HZ = 2'h1;
	localparam logic [1:0] RS_8192HZ = 2'h2;
	// oscillator prescaler, 32768 edges per second
	localparam int PRE_W = 15;
	localparam logic [PRE_W-1:0] PRE_LAST = 15'h7FFF;
	localparam int PRE_BIT_1HZ = 14;
	localparam int PRE_BIT_4096HZ = 2;
	localparam int PRE_BIT_8192HZ = 1;
	// calendar range limits, bcd
	localparam logic [7:0] MAX_SEC = 8'h59;
	localparam logic [7:0] MAX_HOUR24 = 8'h23;
	localparam logic [7:0] MAX_HOUR12 = 8'h12;
	localparam logic [7:0] MAX_WDAY = 8'h07;
	localparam logic [7:0] MAX_DATE = 8'h31;
	localparam logic [7:0] MAX_MONTH = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
endpackage : rtcaic_pkg

// File: hdl/rtcaic_top.sv
// Contract
// - alarm compare values held in 07h-0Dh
// - bit 7 masks each alarm field
// - bit 6 selects weekday or month-day compare
// - satisfied alarm sets its status flag
// - compare only on once-per-second update
// - alarm one masks pick its rate
// - alarm two masks pick rate, seconds zero
// - control bit 7 is free user bit
// - wait flag set at reset, calendar write
// - wait halts clock; clearing restarts counting
// - rate select picks square wave frequency
// - rate select resets to highest frequency
// - routing bit picks wave or alarm pin
// - routing bit resets to square wave
// - enables gate flags onto pins, reset to zero
// - alarm two drives dedicated pin when unrouted
// - oscillator halt flag sticks until cleared
// - bad time write flags, blocks shared pin
// - alarm flags clear by zero write only
`timescale 1ns/1ps
`default_nettype none
module rtcaic_top import rtcaic_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic osc_clk_in,
	input wire logic osc_stopped_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] time_sec_in,
	input wire logic [7:0] time_min_in,
	input wire logic [7:0] time_hour_in,
	input wire logic [7:0] time_wday_in,
	input wire logic [7:0] time_date_in,
	output logic [7:0] reg_rdata_out,
	output logic second_tick_out,
	output logic calendar_halt_out,
	output logic calendar_clear_out,
	output logic wave_or_irq_pin_out,
	output logic alarm_irq_pin_n_out
);

////////////////////////////////////////////////////////////////////////
	// field compare with mask
	function automatic logic field_hit(input logic [7:0] alm,
		input logic [7:0] tv);
		return alm[ALM_MASK_BIT] | (alm[6:0] == tv[6:0]);
	endfunction : field_hit

	// day field compare, weekday or month day
	function automatic logic day_hit(input logic [7:0] alm,
		input logic [7:0] wd, input logic [7:0] dt);
		logic [5:0] sel;
		sel = alm[ALM_DAYSEL_BIT] ? wd[5:0] : dt[5:0];
		return alm[ALM_MASK_BIT] | (alm[5:0] == sel);
	endfunction : day_hit

	// bcd value within limits
	function automatic logic bcd_in(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
	endfunction : bcd_in

	// range check of a calendar write
	function automatic logic cal_ok(input logic [2:0] idx,
		input logic [7:0] v);
		case (idx)
			CAL_SEC, CAL_MIN: cal_ok = bcd_in(v, 8'h00, MAX_SEC);
			CAL_HOUR: cal_ok = v[6] ? (!v[7] && bcd_in({3'h0, v[4:0]}, 8'h01, MAX_HOUR12))
				: bcd_in(v, 8'h00, MAX_HOUR24);
			CAL_WDAY: cal_ok = bcd_in(v, 8'h01, MAX_WDAY);
			CAL_DATE: cal_ok = bcd_in(v, 8'h01, MAX_DATE);
			CAL_MONTH: cal_ok = !v[6] && !v[5] && bcd_in({3'h0, v[4:0]}, 8'h01, MAX_MONTH);
			default: cal_ok = bcd_in(v, 8'h00, MAX_YEAR);
		endcase
	endfunction : cal_ok

////////////////////////////////////////////////////////////////////////
	logic osc_s1_reg, osc_s2_reg, osc_prev_reg;
	logic stop_s1_reg, stop_s2_reg;
	logic [PRE_W-1:0] pre_reg;
	logic tick_d_reg;
	logic [7:0] alm_reg [ALM_REGS];
	logic free_reg, wait_reg, route_reg, alarm_two_irq_enable_reg, alarm_one_irq_enable_reg;
	logic [1:0] rs_reg;
	logic osf_reg, tsa_reg, a2f_reg, a1f_reg;
	logic osc_rise, wr_cal, wr_ctl, wr_sts, wr_alm;
	logic a1_hit, a2_hit, a1_set, a2_set, sq_wave, shared_irq;
	logic [7:0] alm_idx;

	// decoded register writes
	assign wr_cal = reg_wr_in && (reg_addr_in <= ADDR_CAL_LAST);
	assign wr_ctl = reg_wr_in && (reg_addr_in == ADDR_CONTROL);
	assign wr_sts = reg_wr_in && (reg_addr_in == ADDR_STATUS);
	assign wr_alm = reg_wr_in && (reg_addr_in >= ADDR_ALM1_SEC)
		&& (reg_addr_in <= ADDR_ALM2_DAY);
	assign alm_idx = reg_addr_in - ADDR_ALM1_SEC;
	assign osc_rise = osc_s2_reg && !osc_prev_reg;

////////////////////////////////////////////////////////////////////////
	// oscillator and stop detector synchronisers
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			stop_s1_reg <= 1'b0;
			stop_s2_reg <= 1'b0;
		end else begin
			osc_s1_reg <= osc_clk_in;
			osc_s2_reg <= osc_s1_reg;
			osc_prev_reg <= osc_s2_reg;
			stop_s1_reg <= osc_stopped_in;
			stop_s2_reg <= stop_s1_reg;
		end
	end

	// prescaler, restarted when the clock is released
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pre_reg <= '0;
		end else if (wr_ctl && !reg_wdata_in[CTL_WAIT] && wait_reg) begin
			pre_reg <= '0;
		end else if (osc_rise) begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// second tick suppressed while waiting; compare a cycle later
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			second_tick_out <= 1'b0;
			tick_d_reg <= 1'b0;
			calendar_clear_out <= 1'b0;
		end else begin
			second_tick_out <= osc_rise && (pre_reg == PRE_LAST) && !wait_reg;
			tick_d_reg <= second_tick_out;
			calendar_clear_out <= wr_ctl && !reg_wdata_in[CTL_WAIT] && wait_reg;
		end
	end

	assign calendar_halt_out = wait_reg;

////////////////////////////////////////////////////////////////////////
	// alarm compare storage
	genvar gi;
	generate
		for (gi = 0; gi < ALM_REGS; gi++) begin : g_alm
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					alm_reg[gi] <= 8'h00;
				end else if (wr_alm && (alm_idx == 8'(gi))) begin
					alm_reg[gi] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	// alarm matches; masks pick the rate
	assign a1_hit = field_hit(alm_reg[0], time_sec_in)
		&& field_hit(alm_reg[1], time_min_in)
		&& field_hit(alm_reg[2], time_hour_in)
		&& day_hit(alm_reg[3], time_wday_in, time_date_in);
	assign a2_hit = (time_sec_in[6:0] == 7'h00)
		&& field_hit(alm_reg[4], time_min_in)
		&& field_hit(alm_reg[5], time_hour_in)
		&& day_hit(alm_reg[6], time_wday_in, time_date_in);
	assign a1_set = tick_d_reg && a1_hit;
	assign a2_set = tick_d_reg && a2_hit;

////////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			free_reg <= 1'b0;
			wait_reg <= CTL_WAIT_RST;
			rs_reg <= CTL_RS_RST;
			route_reg <= 1'b0;
			alarm_two_irq_enable_reg <= 1'b0;
			alarm_one_irq_enable_reg <= 1'b0;
		end else if (wr_ctl) begin
			free_reg <= reg_wdata_in[CTL_FREE];
			wait_reg <= reg_wdata_in[CTL_WAIT];
			rs_reg <= reg_wdata_in[CTL_RS_HI:CTL_RS_LO];
			route_reg <= reg_wdata_in[CTL_ROUTE];
			alarm_two_irq_enable_reg <= reg_wdata_in[CTL_ALARM_TWO_IRQ_ENABLE];
			alarm_one_irq_enable_reg <= reg_wdata_in[CTL_ALARM_ONE_IRQ_ENABLE];
		end else if (wr_cal) begin
			wait_reg <= 1'b1;
		end
	end

	// status flags: hardware set wins over software clear
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			osf_reg <= STS_OSF_RST;
			tsa_reg <= 1'b0;
			a2f_reg <= 1'b0;
			a1f_reg <= 1'b0;
		end else begin
			if (stop_s2_reg) begin
				osf_reg <= 1'b1;
			end else if (wr_sts && !reg_wdata_in[STS_OSF]) begin
				osf_reg <= 1'b0;
			end
			if (wr_cal && !cal_ok(reg_addr_in[2:0], reg_wdata_in)) begin
				tsa_reg <= 1'b1;
			end else if (wr_sts && !reg_wdata_in[STS_TSA]) begin
				tsa_reg <= 1'b0;
			end
			if (a2_set) begin
				a2f_reg <= 1'b1;
			end else if (wr_sts && !reg_wdata_in[STS_A2F]) begin
				a2f_reg <= 1'b0;
			end
			if (a1_set) begin
				a1f_reg <= 1'b1;
			end else if (wr_sts && !reg_wdata_in[STS_A1F]) begin
				a1f_reg <= 1'b0;
			end
		end
	end

	// register read port
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == ADDR_CONTROL) begin
				reg_rdata_out <= {free_reg, 1'b0, wait_reg, rs_reg, route_reg,
					alarm_two_irq_enable_reg, alarm_one_irq_enable_reg};
			end else if (reg_addr_in == ADDR_STATUS) begin
				reg_rdata_out <= {osf_reg, 4'h0, tsa_reg, a2f_reg, a1f_reg};
			end else if ((reg_addr_in >= ADDR_ALM1_SEC)
				&& (reg_addr_in <= ADDR_ALM2_DAY)) begin
				reg_rdata_out <= alm_reg[alm_idx[2:0]];
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

////////////////////////////////////////////////////////////////////////
	// square wave source
	always_comb begin
		case (rs_reg)
			RS_1HZ: sq_wave = pre_reg[PRE_BIT_1HZ];
			RS_4096HZ: sq_wave = pre_reg[PRE_BIT_4096HZ];
			RS_8192HZ: sq_wave = pre_reg[PRE_BIT_8192HZ];
			default: sq_wave = osc_s2_reg;
		endcase
	end

	// shared alarm level, blocked while a bad time write is pending
	assign shared_irq = ((a1f_reg && alarm_one_irq_enable_reg) || (a2f_reg && alarm_two_irq_enable_reg))
		&& !tsa_reg;

	// output pins, active low alarm levels
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wave_or_irq_pin_out <= 1'b1;
			alarm_irq_pin_n_out <= 1'b1;
		end else begin
			wave_or_irq_pin_out <= route_reg ? !shared_irq : sq_wave;
			alarm_irq_pin_n_out <= !(!route_reg && a2f_reg && alarm_two_irq_enable_reg);
		end
	end

////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_alarm1_sets: assert property (a1_set |=> a1f_reg)
		else $error("alarm one match did not set flag");
	a_alarm_on_tick: assert property ($rose(a2f_reg) |-> $past(tick_d_reg))
		else $error("alarm two flag rose without a second update");
	a_flag_clear: assert property (wr_sts && !reg_wdata_in[STS_A1F] && !a1_set
		|=> !a1f_reg)
		else $error("alarm one flag not cleared by zero write");
	a_flag_one_write: assert property (wr_sts && reg_wdata_in[STS_A2F] && !a2f_reg
		&& !a2_set |=> !a2f_reg)
		else $error("writing one changed alarm two flag");
	a_wait_on_cal: assert property (wr_cal |=> wait_reg && calendar_halt_out)
		else $error("calendar write did not set wait flag");
	a_halt_no_tick: assert property (wait_reg |=> !second_tick_out)
		else $error("second tick while clock halted");
	a_wave_route: assert property (!route_reg |=> wave_or_irq_pin_out == $past(sq_wave))
		else $error("shared pin not carrying square wave");
	a_tsa_blocks: assert property (tsa_reg && route_reg |=> wave_or_irq_pin_out)
		else $error("shared pin triggered during time error");
	a_alarm2_pin: assert property (!route_reg && a2f_reg && alarm_two_irq_enable_reg
		|=> !alarm_irq_pin_n_out)
		else $error("alarm two pin not low");
	a_irq_level: assert property (route_reg && a1f_reg && alarm_one_irq_enable_reg && !tsa_reg
		&& $stable(route_reg) [*2] |-> !wave_or_irq_pin_out)
		else $error("shared interrupt level dropped");
	a_osf_sticky: assert property (osf_reg && !(wr_sts && !reg_wdata_in[STS_OSF])
		|=> osf_reg)
		else $error("oscillator halt flag dropped");

	// flag setting follows the second update only
	a_alarm2_sets: assert property (a2_set |=> a2f_reg)
		else $error("alarm two match did not set flag");
	a_alarm1_on_tick: assert property ($rose(a1f_reg) |-> $past(tick_d_reg))
		else $error("alarm one flag rose without a second update");

	// restart clears the calendar and the prescaler together
	a_restart_pulse: assert property (wr_ctl && !reg_wdata_in[CTL_WAIT] && wait_reg
		|=> calendar_clear_out && (pre_reg == '0))
		else $error("restart did not clear calendar and prescaler");

	// sticky flags and the free bit
	a_tsa_sticky: assert property (tsa_reg && !(wr_sts && !reg_wdata_in[STS_TSA])
		|=> tsa_reg)
		else $error("time error flag dropped");
	a_osc_stop_sets: assert property (stop_s2_reg |=> osf_reg)
		else $error("oscillator stop did not set halt flag");
	a_free_bit: assert property (wr_ctl |=> free_reg == $past(reg_wdata_in[CTL_FREE]))
		else $error("free bit not stored");

	// pin levels follow flag and enable
	a_alarm_route: assert property (route_reg && shared_irq
		|=> !wave_or_irq_pin_out)
		else $error("shared pin not low on routed alarm");
	a_alarm2_release: assert property (!a2f_reg || !alarm_two_irq_enable_reg
		|=> alarm_irq_pin_n_out)
		else $error("alarm two pin held low without flag");

	c_alarm1_fire: cover property (a1_set && alarm_one_irq_enable_reg && route_reg);
	c_alarm2_fire: cover property (a2_set && !route_reg);
	c_restart: cover property (calendar_clear_out ##[1:8] !wait_reg);
	c_time_error: cover property ($rose(tsa_reg));
	c_alarm2_shared: cover property (a2_set && route_reg && alarm_two_irq_enable_reg);

endmodule : rtcaic_top
`default_nettype wire

// File: verification/rtcaic_time_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcaic_time_model (
	input wire logic ref_clk_in,
	input wire logic tick_in,
	input wire logic [39:0] next_time_in,
	output logic osc_clk_out,
	output logic [39:0] time_out = 40'h0
);
	////////////////////////////////////////////////////////////////////////
	// free running crystal, phase unrelated to the system clock
	initial begin
		osc_clk_out = 1'b0;
		#137;
		forever #200 osc_clk_out = ~osc_clk_out;
	end
	////////////////////////////////////////////////////////////////////////
	// time registers take the new value at the timekeeping advance only
	always @(posedge ref_clk_in) begin
		if (tick_in === 1'b1) begin
			time_out <= next_time_in;
		end
	end
endmodule : rtcaic_time_model
`default_nettype wire

// File: verification/rtc_alarm_irq_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_irq_control_test import rtcaic_pkg::*; ;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic osc_clk, tick, halt, clr, wave_pin, irq_n;
	logic osc_stopped = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wave_q = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
	logic [39:0] time_now, time_next = 40'h0;
	logic [7:0] alm [7];
	int fail_count = 0, tests_run = 0, seed = 32'hf1f7, edges = 0, clears = 0;
	////////////////////////////////////////////////////////////////////////
	// clock, partner and design
	always #25 ref_clk_in = ~ref_clk_in;
	rtcaic_time_model model (.ref_clk_in(ref_clk_in), .tick_in(tick),
		.next_time_in(time_next), .osc_clk_out(osc_clk), .time_out(time_now));
	rtcaic_top dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.osc_clk_in(osc_clk), .osc_stopped_in(osc_stopped),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .time_sec_in(time_now[7:0]),
		.time_min_in(time_now[15:8]), .time_hour_in(time_now[23:16]),
		.time_wday_in(time_now[31:24]), .time_date_in(time_now[39:32]),
		.reg_rdata_out(rdata), .second_tick_out(tick),
		.calendar_halt_out(halt), .calendar_clear_out(clr),
		.wave_or_irq_pin_out(wave_pin), .alarm_irq_pin_n_out(irq_n));
	// counts square wave rising edges and calendar clear pulses mid-cycle
	always @(negedge ref_clk_in) begin
		wave_q <= wave_pin;
		if (wave_pin === 1'b1 && wave_q === 1'b0) edges <= edges + 1;
		if (clr === 1'b1) clears <= clears + 1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : cyc
	// one write strobe, held over exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rchk(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		cyc(1);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		cyc(1);
		chk(what, rdata, exp);
	endtask : rchk
	// reference alarm compare, masked fields always hit
	function automatic logic [1:0] exp_alarm(input logic [39:0] t);
		logic [3:0] h1;
		logic [2:0] h2;
		h1[0] = alm[0][7] | (alm[0][6:0] == t[6:0]);
		h1[1] = alm[1][7] | (alm[1][6:0] == t[14:8]);
		h1[2] = alm[2][7] | (alm[2][6:0] == t[22:16]);
		h1[3] = alm[3][7] | (alm[3][5:0] == (alm[3][6] ? t[29:24] : t[37:32]));
		h2[0] = alm[4][7] | (alm[4][6:0] == t[14:8]);
		h2[1] = alm[5][7] | (alm[5][6:0] == t[22:16]);
		h2[2] = alm[6][7] | (alm[6][5:0] == (alm[6][6] ? t[29:24] : t[37:32]));
		return {(t[6:0] == 7'h00) & (&h2), &h1};
	endfunction : exp_alarm
	// one second: program both alarms, wait for the advance, check outcome
	task automatic run_tick(input logic [7:0] ctl, input logic zs,
		input logic time_value_error_flag, input int restarts);
		int n, k1, k2, c0;
		logic [7:0] v;
		logic [5:0] d;
		logic [1:0] f;
		logic w;
		k1 = $unsigned($random(seed)) % 5;
		k2 = $unsigned($random(seed)) % 4;
		for (n = 0; n < 7; n++) begin
			v = 8'($random(seed));
			if (n > 3) v = alm[n - 3];
			v[7] = (n < 4) ? n >= k1 : n - 4 >= k2;
			if (n < 3) v[6] = 1'b0;
			if (n == 0) v[0] = 1'b1;
			alm[n] = v;
			wr(8'(ADDR_ALM1_SEC + n), v);
			rchk("alarm reg", 8'(ADDR_ALM1_SEC + n), v);
		end
		d = alm[3][5:0];
		time_next = {2'b00, alm[3][6] ? d + 6'h01 : d, 2'b00,
			alm[3][6] ? d : d + 6'h01, 2'b00, alm[2][5:0], 2'b00,
			alm[1][5:0], 2'b00, zs ? 6'h00 : alm[0][5:0]};
		c0 = clears;
		wr(ADDR_CONTROL, ctl);
		rchk("control", ADDR_CONTROL, ctl);
		chk("clear pulse", 8'(clears - c0), 8'(restarts));
		rchk("no early flag", ADDR_STATUS, {5'h00, time_value_error_flag, 2'h0});
		n = 0;
		while (tick !== 1'b1 && n < 300000) begin
			cyc(1);
			n++;
		end
		chk("second tick", {7'h00, tick}, 8'h01);
		w = wave_pin;
		cyc(5);
		f = exp_alarm(time_next);
		rchk("status", ADDR_STATUS, {5'h00, time_value_error_flag, f});
		if (ctl[2]) begin
			chk("shared pin", wave_pin,
				!(!time_value_error_flag && (f[0] && ctl[0] || f[1] && ctl[1])));
		end else begin
			chk("alarm pin", irq_n, !(f[1] && ctl[1]));
			if (ctl[4:3] == RS_1HZ) chk("slow wave", {w, wave_pin}, 8'h02);
		end
		wr(ADDR_STATUS, {5'h00, time_value_error_flag, 2'h3});
		rchk("flags kept", ADDR_STATUS, {5'h00, time_value_error_flag, f});
		wr(ADDR_STATUS, 8'h00);
		rchk("flags cleared", ADDR_STATUS, 8'h00);
		chk("pin released", ctl[2] ? wave_pin : irq_n, 1);
	endtask : run_tick
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////
	// watchdog sized for four oscillator seconds
	initial begin
		repeat (1100000) @(posedge ref_clk_in);
		fail_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		int e0, d, n;
		cyc(3);
		sys_rst_in = 1'b0;
		rchk("control", ADDR_CONTROL, 8'h38);
		rchk("status", ADDR_STATUS, 8'h80);
		chk("halt", halt, 1);
		wr(ADDR_STATUS, 8'h00);
		rchk("osc flag", ADDR_STATUS, 8'h00);
		osc_stopped = 1'b1;
		cyc(6);
		osc_stopped = 1'b0;
		cyc(6);
		rchk("osc flag", ADDR_STATUS, 8'h80);
		wr(ADDR_STATUS, 8'h00);
		rchk("unmapped", 8'h10, 8'h00);
		e0 = clears;
		for (n = 1; n < 4; n++) begin
			wr(ADDR_CONTROL, 8'(n << 3));
			d = edges;
			cyc(1024);
			d = edges - d - (n == 3 ? 128 : 8 << n);
			chk("wave rate", d >= -1 && d <= 1, 1);
		end
		chk("clear pulse", 8'(clears - e0), 1);
		chk("halt", halt, 0);
		run_tick(8'h85, 1'b0, 1'b0, 0);
		run_tick(8'h02, 1'b1, 1'b0, 0);
		wr(8'h00, 8'h60);
		rchk("bad time", ADDR_STATUS, 8'h04);
		rchk("wait set", ADDR_CONTROL, 8'h22);
		run_tick(8'h05, 1'b0, 1'b1, 1);
		tally_and_finish();
	end
endmodule : rtc_alarm_irq_control_test
`default_nettype wire
